// ### design/clc_pkg.sv
// Operation
// - Any six-input function, some seven-input functions.
// - Each flop: data, clock, enable, clears, load.
// - Combinational results bypass the flops entirely.
// - Two output sets, two drivers, one local.
// - Flop output may feed back into LUT.
// - Registered and unregistered results shown together.
// - Exactly one configured mode at a time.
// - Eleven inputs: eight data, carry, shared, chain.
// - Cluster-wide controls drive flops in every mode.
// - Normal mode: two functions or one six-input.
// - Two five-input functions share both first inputs.
// - Four plus five shares first or second input.
// - Two six-input functions: four shared, identical.
// - Upper select pair feeds upper flop, lower lower.
// - Lower six-input frees upper pair for packing.
// - Lower second select packs only if unregistered.
// - Extended: selector between two shared five-input functions.
// - Extended unregistered: eighth input packs, lower flop off.
// - Smaller function pairs also accepted in normal mode.
package clc_pkg;

  localparam int ADDR_W = 5;

  localparam logic [ADDR_W-1:0] MODE_CTRL_OFS = 5'h00;
  localparam logic [ADDR_W-1:0] UPPER_MASK_LO_OFS = 5'h04;
  localparam logic [ADDR_W-1:0] UPPER_MASK_HI_OFS = 5'h08;
  localparam logic [ADDR_W-1:0] LOWER_MASK_LO_OFS = 5'h0c;
  localparam logic [ADDR_W-1:0] LOWER_MASK_HI_OFS = 5'h10;
  localparam logic [ADDR_W-1:0] FLOP_CFG_OFS = 5'h14;
  localparam logic [ADDR_W-1:0] OUT_CFG_OFS = 5'h18;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 5'h1c;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Mode codes, one-hot.
  localparam logic [4:0] MODE_NORMAL = 5'h01;
  localparam logic [4:0] MODE_EXTENDED = 5'h02;
  localparam logic [4:0] MODE_ARITH = 5'h04;
  localparam logic [4:0] MODE_SHARED = 5'h08;
  localparam logic [4:0] MODE_LUTREG = 5'h10;
  localparam logic [4:0] MODE_RST = MODE_NORMAL;

  // Flop data source codes.
  localparam logic [1:0] DSRC_COMB = 2'h0;
  localparam logic [1:0] DSRC_PACK = 2'h1;
  localparam logic [1:0] DSRC_CHAIN = 2'h2;
  localparam logic [1:0] DSRC_OFF = 2'h3;

  // Flop configuration byte fields, upper flop in bits 7:0, lower in 15:8.
  localparam int FC_DSRC_LSB = 0;
  localparam int FC_GATE_LSB = 2;
  localparam int FC_ACLR_SEL = 4;
  localparam int FC_ACLR_EN = 5;
  localparam int FC_SCLR_EN = 6;
  localparam int FC_SLOAD_EN = 7;
  localparam int FC_LOWER_LSB = 8;
  localparam logic [15:0] FLOP_CFG_RST = 16'hffff;

  // Output configuration: a set bit selects the registered value.
  localparam int OC_UPPER_LSB = 0;
  localparam int OC_LOWER_LSB = 3;
  localparam int OC_FB_UPPER = 6;
  localparam int OC_FB_LOWER = 7;
  localparam logic [7:0] OUT_CFG_RST = 8'h00;

  // Status fields.
  localparam int ST_UDEP_LSB = 0;
  localparam int ST_LDEP_LSB = 8;
  localparam int ST_CFG_ERR = 16;
  localparam int ST_UQ = 17;
  localparam int ST_LQ = 18;
  localparam int ST_LUTREG_Q = 19;

  typedef struct packed {
    logic aw_got;
    logic [ADDR_W-1:0] aw_addr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [4:0] mode;
    logic [63:0] umask;
    logic [63:0] lmask;
    logic [15:0] flop_cfg;
    logic [7:0] out_cfg;
  } clc_state_t;

  function automatic logic [31:0] clc_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : clc_merge

  // Inputs on which a six-input truth table really depends.
  function automatic logic [5:0] clc_deps(input logic [63:0] mask);
    logic [5:0] d;
    d = 6'h00;
    for (int i = 0; i < 6; i++) begin
      for (int j = 0; j < 64; j++) begin
        if (((j >> i) & 1) == 0) begin
          d[i] = d[i] | (mask[j] ^ mask[j + (1 << i)]);
        end
      end
    end
    return d;
  endfunction : clc_deps

  function automatic logic [2:0] clc_count(input logic [5:0] v);
    logic [2:0] c;
    c = 3'h0;
    for (int i = 0; i < 6; i++) begin
      c = c + {2'h0, v[i]};
    end
    return c;
  endfunction : clc_count

endpackage : clc_pkg

// ### design/clc_flop.sv
`timescale 1ns/1ps
`default_nettype none
// One programmable flip-flop of the cell.
module clc_flop (
  input wire logic clk,
  input wire logic rst,
  input wire logic aclr,
  input wire logic ce,
  input wire logic sclr,
  input wire logic sload,
  input wire logic sload_data,
  input wire logic d,
  output logic q
);
  import clc_pkg::*;

  typedef struct packed {
    logic q;
  } clc_flop_state_t;

  clc_flop_state_t s_q;
  clc_flop_state_t s_d;
  logic clr_any;

  assign clr_any = rst | aclr;
  assign q = s_q.q;

  always_comb begin
    s_d = s_q;
    if (ce) begin
      if (sclr) begin
        s_d.q = 1'b0;
      end else if (sload) begin
        s_d.q = sload_data;
      end else begin
        s_d.q = d;
      end
    end
  end

  // The clear is asynchronous and beats every clocked control.
  always_ff @(posedge clk or posedge clr_any) begin
    if (clr_any) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule : clc_flop
`default_nettype wire

// ### design/clc_cell.sv
// Design decisions made here: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module clc_cell (
  input wire logic CLK_SYS,
  input wire logic RESET,
  input wire logic [clc_pkg::ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [clc_pkg::ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic [3:0] SHARED_DATA,
  input wire logic UPPER_SELECT_FIRST,
  input wire logic UPPER_SELECT_SECOND,
  input wire logic LOWER_SELECT_FIRST,
  input wire logic LOWER_SELECT_SECOND,
  input wire logic CARRY_IN,
  input wire logic SHARED_CHAIN_IN,
  input wire logic REG_CHAIN_IN,
  input wire logic CLUSTER_CLOCK_GATE_A,
  input wire logic CLUSTER_CLOCK_GATE_B,
  input wire logic CLUSTER_CLOCK_GATE_C,
  input wire logic CLUSTER_ASYNC_CLEAR_A,
  input wire logic CLUSTER_ASYNC_CLEAR_B,
  input wire logic CLUSTER_SYNC_CLEAR,
  input wire logic CLUSTER_SYNC_LOAD,
  output logic [1:0] UPPER_ROUTE_OUT,
  output logic UPPER_LOCAL_OUT,
  output logic [1:0] LOWER_ROUTE_OUT,
  output logic LOWER_LOCAL_OUT,
  output logic UPPER_COMB_OUTPUT,
  output logic LOWER_COMB_OUTPUT,
  output logic CARRY_OUT,
  output logic SHARED_CHAIN_OUT,
  output logic REG_CHAIN_OUT
);
  import clc_pkg::*;

  clc_state_t s_q;
  clc_state_t s_d;

  logic a_in;
  logic b_in;
  logic c_in;
  logic d_in;
  logic e0_in;
  logic f0_in;
  logic e1_in;
  logic f1_in;
  logic upper_q;
  logic lower_q;
  logic lutreg_q;
  logic [5:0] udep;
  logic [5:0] ldep;
  logic [2:0] ucnt;
  logic [2:0] lcnt;
  logic [3:0] common_in;
  logic pack_err;
  logic flop_err;
  logic cfg_err;
  logic [15:0] fc;
  logic [1:0] udsrc;
  logic [1:0] ldsrc;
  logic u_lut;
  logic l_lut;
  logic u_res;
  logic l_res;
  logic sum0;
  logic sum1;
  logic carry0;
  logic carry1;
  logic shared_mid;
  logic shared_out;
  logic u_ff_d;
  logic l_ff_d;
  logic u_ce;
  logic l_ce;
  logic u_aclr;
  logic l_aclr;
  logic [31:0] rd_word;
  logic rd_hit;
  logic wr_hit;

  // The eight data inputs, with feedback optionally replacing the second selects.
  assign a_in = SHARED_DATA[0];
  assign b_in = SHARED_DATA[1];
  assign c_in = SHARED_DATA[2];
  assign d_in = SHARED_DATA[3];
  assign e0_in = UPPER_SELECT_FIRST;
  assign e1_in = LOWER_SELECT_FIRST;
  assign f0_in = s_q.out_cfg[OC_FB_UPPER] ? upper_q : UPPER_SELECT_SECOND;
  assign f1_in = s_q.out_cfg[OC_FB_LOWER] ? lower_q : LOWER_SELECT_SECOND;

  assign fc = s_q.flop_cfg;
  assign udsrc = fc[FC_DSRC_LSB +: 2];
  assign ldsrc = fc[FC_LOWER_LSB + FC_DSRC_LSB +: 2];

  // Packing legality is derived from what each truth table actually depends on.
  // Bits 3:0 are the shared inputs a..d, bits 5:4 the half's own select pair.
  assign udep = clc_deps(s_q.umask);
  assign ldep = clc_deps(s_q.lmask);
  assign ucnt = clc_count(udep);
  assign lcnt = clc_count(ldep);
  assign common_in = udep[3:0] & ldep[3:0];

  always_comb begin
    pack_err = 1'b0;
    if (ucnt == 3'h6 && lcnt == 3'h6) begin
      pack_err = !(common_in == 4'hf && s_q.umask == s_q.lmask);
    end else if (ucnt == 3'h6 || lcnt == 3'h6) begin
      pack_err = (ucnt != 3'h0) && (lcnt != 3'h0);
    end else if (ucnt == 3'h5 && lcnt == 3'h5) begin
      pack_err = common_in[1:0] != 2'h3;
    end else if ((ucnt == 3'h5 && lcnt == 3'h4) || (ucnt == 3'h4 && lcnt == 3'h5)) begin
      pack_err = !(common_in[0] | common_in[1]);
    end
  end

  // Register packing sources are only legal when the pin is otherwise idle.
  always_comb begin
    flop_err = 1'b0;
    if (s_q.mode == MODE_NORMAL) begin
      if (udsrc == DSRC_PACK && udep[5:4] != 2'h0) begin
        flop_err = 1'b1;
      end
      if (ldsrc == DSRC_PACK && (ldep[5] || udsrc == DSRC_COMB)) begin
        flop_err = 1'b1;
      end
    end else if (s_q.mode == MODE_EXTENDED) begin
      // The packed register needs a driver of its own, so one must still show the table.
      if (udsrc == DSRC_PACK && s_q.out_cfg[OC_UPPER_LSB +: 3] == 3'h7) begin
        flop_err = 1'b1;
      end
    end
  end

  assign cfg_err = (s_q.mode == MODE_NORMAL && pack_err) || flop_err;

  // Adders: two four-input tables per adder in the arithmetic modes.
  always_comb begin
    logic x0;
    logic y0;
    logic x1;
    logic y1;
    x0 = s_q.umask[{e0_in, c_in, b_in, a_in}];
    y0 = s_q.umask[6'h10 + {2'h0, f0_in, d_in, b_in, a_in}];
    x1 = s_q.lmask[{e1_in, c_in, b_in, a_in}];
    y1 = s_q.lmask[6'h10 + {2'h0, f1_in, d_in, b_in, a_in}];
    shared_mid = 1'b0;
    shared_out = 1'b0;
    if (s_q.mode == MODE_SHARED) begin
      // Three-input add: the second table of each half forms the chain carry.
      shared_mid = y0;
      shared_out = y1;
      y0 = SHARED_CHAIN_IN;
      y1 = shared_mid;
    end
    sum0 = x0 ^ y0 ^ CARRY_IN;
    carry0 = (x0 & y0) | (CARRY_IN & (x0 ^ y0));
    sum1 = x1 ^ y1 ^ carry0;
    carry1 = (x1 & y1) | (carry0 & (x1 ^ y1));
  end

  // Combinational results per mode; an illegal packing blanks both halves.
  always_comb begin
    u_lut = s_q.umask[{f0_in, e0_in, d_in, c_in, b_in, a_in}];
    l_lut = s_q.lmask[{f1_in, e1_in, d_in, c_in, b_in, a_in}];
    u_res = 1'b0;
    l_res = 1'b0;
    unique case (s_q.mode)
      MODE_NORMAL: begin
        u_res = u_lut;
        l_res = l_lut;
      end
      MODE_EXTENDED: begin
        u_res = f0_in ? s_q.lmask[{1'b0, e1_in, d_in, c_in, b_in, a_in}]
                      : s_q.umask[{1'b0, e0_in, d_in, c_in, b_in, a_in}];
      end
      MODE_ARITH, MODE_SHARED: begin
        u_res = sum0;
        l_res = sum1;
      end
      MODE_LUTREG: begin
        u_res = u_lut;
        l_res = lutreg_q;
      end
      default: begin
        u_res = 1'b0;
        l_res = 1'b0;
      end
    endcase
    if (cfg_err) begin
      u_res = 1'b0;
      l_res = 1'b0;
    end
  end

  // Flop data and cluster control selection.
  always_comb begin
    unique case (udsrc)
      DSRC_COMB: u_ff_d = u_res;
      DSRC_PACK: u_ff_d = (s_q.mode == MODE_EXTENDED) ? LOWER_SELECT_SECOND : UPPER_SELECT_FIRST;
      DSRC_CHAIN: u_ff_d = REG_CHAIN_IN;
      default: u_ff_d = upper_q;
    endcase
    unique case (ldsrc)
      DSRC_COMB: l_ff_d = l_res;
      DSRC_PACK: l_ff_d = LOWER_SELECT_SECOND;
      DSRC_CHAIN: l_ff_d = upper_q;
      default: l_ff_d = lower_q;
    endcase
  end

  function automatic logic gate_sel(input logic [1:0] sel, input logic ga, input logic gb, input logic gc);
    logic g;
    g = 1'b1;
    if (sel == 2'h1) begin
      g = ga;
    end else if (sel == 2'h2) begin
      g = gb;
    end else if (sel == 2'h3) begin
      g = gc;
    end
    return g;
  endfunction : gate_sel

  // Any selected gate of the cluster turns a flop on or off; in extended mode the lower flop stays off.
  assign u_ce = (udsrc != DSRC_OFF) && !flop_err &&
                gate_sel(fc[FC_GATE_LSB +: 2], CLUSTER_CLOCK_GATE_A, CLUSTER_CLOCK_GATE_B,
                         CLUSTER_CLOCK_GATE_C);
  assign l_ce = (ldsrc != DSRC_OFF) && !flop_err && (s_q.mode != MODE_EXTENDED) &&
                gate_sel(fc[FC_LOWER_LSB + FC_GATE_LSB +: 2], CLUSTER_CLOCK_GATE_A,
                         CLUSTER_CLOCK_GATE_B, CLUSTER_CLOCK_GATE_C);
  // The clear selection comes from registers, so only the cluster pins can glitch it.
  assign u_aclr = fc[FC_ACLR_EN] &
                  (fc[FC_ACLR_SEL] ? CLUSTER_ASYNC_CLEAR_B : CLUSTER_ASYNC_CLEAR_A);
  assign l_aclr = fc[FC_LOWER_LSB + FC_ACLR_EN] &
                  (fc[FC_LOWER_LSB + FC_ACLR_SEL] ? CLUSTER_ASYNC_CLEAR_B : CLUSTER_ASYNC_CLEAR_A);

  clc_flop u_upper_flip_flop (
    .clk(CLK_SYS),
    .rst(RESET),
    .aclr(u_aclr),
    .ce(u_ce),
    .sclr(CLUSTER_SYNC_CLEAR & fc[FC_SCLR_EN]),
    .sload(CLUSTER_SYNC_LOAD & fc[FC_SLOAD_EN]),
    .sload_data(c_in),
    .d(u_ff_d),
    .q(upper_q)
  );

  clc_flop u_lower_flip_flop (
    .clk(CLK_SYS),
    .rst(RESET),
    .aclr(l_aclr),
    .ce(l_ce),
    .sclr(CLUSTER_SYNC_CLEAR & fc[FC_LOWER_LSB + FC_SCLR_EN]),
    .sload(CLUSTER_SYNC_LOAD & fc[FC_LOWER_LSB + FC_SLOAD_EN]),
    .sload_data(c_in),
    .d(l_ff_d),
    .q(lower_q)
  );

  // The third register of the table-register mode shares the upper flop's enable and async clear; it has no sync clear or load.
  clc_flop u_table_reg (
    .clk(CLK_SYS),
    .rst(RESET),
    .aclr(u_aclr),
    .ce(u_ce && s_q.mode == MODE_LUTREG),
    .sclr(1'b0),
    .sload(1'b0),
    .sload_data(1'b0),
    .d(l_lut),
    .q(lutreg_q)
  );

  // Each driver picks comb or registered on its own, so both can show at once.
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      UPPER_ROUTE_OUT[i] = s_q.out_cfg[OC_UPPER_LSB + i] ? upper_q : u_res;
      LOWER_ROUTE_OUT[i] = s_q.out_cfg[OC_LOWER_LSB + i] ? lower_q : l_res;
    end
    UPPER_LOCAL_OUT = s_q.out_cfg[OC_UPPER_LSB + 2] ? upper_q : u_res;
    LOWER_LOCAL_OUT = s_q.out_cfg[OC_LOWER_LSB + 2] ? lower_q : l_res;
  end

  assign UPPER_COMB_OUTPUT = u_res;
  assign LOWER_COMB_OUTPUT = l_res;
  assign CARRY_OUT = carry1;
  assign SHARED_CHAIN_OUT = shared_out;
  assign REG_CHAIN_OUT = lower_q;

  // Register read map.
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit = 1'b1;
    unique case (S_AXI_ARADDR)
      MODE_CTRL_OFS: rd_word[4:0] = s_q.mode;
      UPPER_MASK_LO_OFS: rd_word = s_q.umask[31:0];
      UPPER_MASK_HI_OFS: rd_word = s_q.umask[63:32];
      LOWER_MASK_LO_OFS: rd_word = s_q.lmask[31:0];
      LOWER_MASK_HI_OFS: rd_word = s_q.lmask[63:32];
      FLOP_CFG_OFS: rd_word[15:0] = s_q.flop_cfg;
      OUT_CFG_OFS: rd_word[7:0] = s_q.out_cfg;
      STATUS_OFS: begin
        rd_word[ST_UDEP_LSB +: 6] = udep;
        rd_word[ST_LDEP_LSB +: 6] = ldep;
        rd_word[ST_CFG_ERR] = cfg_err;
        rd_word[ST_UQ] = upper_q;
        rd_word[ST_LQ] = lower_q;
        rd_word[ST_LUTREG_Q] = lutreg_q;
      end
      default: rd_hit = 1'b0;
    endcase
  end

  assign wr_hit = (s_q.aw_addr == MODE_CTRL_OFS) || (s_q.aw_addr == UPPER_MASK_LO_OFS) ||
                  (s_q.aw_addr == UPPER_MASK_HI_OFS) || (s_q.aw_addr == LOWER_MASK_LO_OFS) ||
                  (s_q.aw_addr == LOWER_MASK_HI_OFS) || (s_q.aw_addr == FLOP_CFG_OFS) ||
                  (s_q.aw_addr == OUT_CFG_OFS);

  assign S_AXI_AWREADY = !s_q.aw_got && !s_q.bvalid;
  assign S_AXI_WREADY = !s_q.w_got && !s_q.bvalid;
  assign S_AXI_ARREADY = !s_q.rvalid;
  assign S_AXI_BVALID = s_q.bvalid;
  assign S_AXI_BRESP = s_q.bresp;
  assign S_AXI_RVALID = s_q.rvalid;
  assign S_AXI_RDATA = s_q.rdata;
  assign S_AXI_RRESP = s_q.rresp;

  always_comb begin
    logic [31:0] m;
    m = 32'h0000_0000;
    s_d = s_q;
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      s_d.aw_got = 1'b1;
      s_d.aw_addr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      s_d.w_got = 1'b1;
      s_d.wdata = S_AXI_WDATA;
      s_d.wstrb = S_AXI_WSTRB;
    end
    if (s_q.aw_got && s_q.w_got) begin
      s_d.aw_got = 1'b0;
      s_d.w_got = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = wr_hit ? RESP_OKAY : RESP_SLVERR;
      unique case (s_q.aw_addr)
        MODE_CTRL_OFS: begin
          m = clc_merge({27'h0000000, s_q.mode}, s_q.wdata, s_q.wstrb);
          // A code that is not exactly one mode is refused and the old mode kept.
          if (m[4:0] == MODE_NORMAL || m[4:0] == MODE_EXTENDED || m[4:0] == MODE_ARITH ||
              m[4:0] == MODE_SHARED || m[4:0] == MODE_LUTREG) begin
            s_d.mode = m[4:0];
          end
        end
        UPPER_MASK_LO_OFS: s_d.umask[31:0] = clc_merge(s_q.umask[31:0], s_q.wdata, s_q.wstrb);
        UPPER_MASK_HI_OFS: s_d.umask[63:32] = clc_merge(s_q.umask[63:32], s_q.wdata, s_q.wstrb);
        LOWER_MASK_LO_OFS: s_d.lmask[31:0] = clc_merge(s_q.lmask[31:0], s_q.wdata, s_q.wstrb);
        LOWER_MASK_HI_OFS: s_d.lmask[63:32] = clc_merge(s_q.lmask[63:32], s_q.wdata, s_q.wstrb);
        FLOP_CFG_OFS: begin
          m = clc_merge({16'h0000, s_q.flop_cfg}, s_q.wdata, s_q.wstrb);
          s_d.flop_cfg = m[15:0];
        end
        OUT_CFG_OFS: begin
          m = clc_merge({24'h000000, s_q.out_cfg}, s_q.wdata, s_q.wstrb);
          s_d.out_cfg = m[7:0];
        end
        default: m = 32'h0000_0000;
      endcase
    end
    if (s_q.bvalid && S_AXI_BREADY) begin
      s_d.bvalid = 1'b0;
    end
    if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      s_d.rvalid = 1'b1;
      s_d.rdata = rd_word;
      s_d.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_q.rvalid && S_AXI_RREADY) begin
      s_d.rvalid = 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      s_q <= '0;
      s_q.mode <= MODE_RST;
      s_q.flop_cfg <= FLOP_CFG_RST;
      s_q.out_cfg <= OUT_CFG_RST;
    end else begin
      s_q <= s_d;
    end
  end

endmodule : clc_cell
`default_nettype wire

// ### test/clc_cell_checker.sv
`timescale 1ns/1ps
`default_nettype none
module clc_cell_checker (
  input wire logic CLK_SYS,
  input wire logic RESET,
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RESET);
  // The register port is only a configuration path, so these guard the handshake only.
  reset_idle_a: assert property ($fell(RESET) |-> S_AXI_AWREADY && S_AXI_WREADY && S_AXI_ARREADY && !S_AXI_BVALID)
    else $error("ready flags wrong after reset");
  bresp_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response dropped early");
  rdata_hold_a: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read data dropped early");
  ar_block_a: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
    else $error("read address accepted during answer");
  w_block_a: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
    else $error("write accepted during response");
  rd_answer_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read answer late");
  wr_answer_a: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
    |=> !S_AXI_BVALID ##1 S_AXI_BVALID)
    else $error("write answer timing wrong");
  b_done_a: assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID && S_AXI_AWREADY)
    else $error("write response not retired");
  r_done_a: assert property (S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID && S_AXI_ARREADY)
    else $error("read answer not retired");
  cover property (S_AXI_BVALID && S_AXI_BREADY && S_AXI_BRESP == 2'h2);
  cover property (S_AXI_BVALID && S_AXI_BREADY && S_AXI_BRESP == 2'h0);
  cover property (S_AXI_RVALID && S_AXI_RREADY);
endmodule : clc_cell_checker
bind clc_cell clc_cell_checker chk_u (.*);
`default_nettype wire

// ### test/clc_fabric_model.sv
`timescale 1ns/1ps
`default_nettype none
// Routing side: shared a..d, e0, f0, e1, f1, carry, shared chain, register chain.
// Cluster side: gates A..C, async clears A and B, sync clear, sync load.
module clc_fabric_model (
  output var logic [10:0] dat,
  output var logic [6:0] ctl
);
  initial dat = 11'h000;
  initial ctl = 7'h07;
  task automatic set_dat(input logic [10:0] v);
    dat <= v;
  endtask : set_dat
  task automatic set_ctl(input logic [6:0] v);
    ctl <= v;
  endtask : set_ctl
endmodule : clc_fabric_model
`default_nettype wire

// ### test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import clc_pkg::*;
  logic CLK_SYS = 1'b0;
  logic RESET = 1'b1;
  logic [ADDR_W-1:0] S_AXI_AWADDR = 5'h00, S_AXI_ARADDR = 5'h00;
  logic [31:0] S_AXI_WDATA = 32'h0, S_AXI_RDATA, rd;
  logic [3:0] S_AXI_WSTRB = 4'hf;
  logic S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b0, S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0;
  logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP, UPPER_ROUTE_OUT, LOWER_ROUTE_OUT;
  logic UPPER_LOCAL_OUT, LOWER_LOCAL_OUT, UPPER_COMB_OUTPUT, LOWER_COMB_OUTPUT, CARRY_OUT, SHARED_CHAIN_OUT;
  logic REG_CHAIN_OUT;
  logic [10:0] dat;
  logic [6:0] ctl;
  int err_total = 0;
  int checks = 0;
  int cyc = 0;
  clc_fabric_model fab_u (.dat(dat), .ctl(ctl));
  clc_cell dut_u (
    .SHARED_DATA(dat[3:0]),
    .UPPER_SELECT_FIRST(dat[4]),
    .UPPER_SELECT_SECOND(dat[5]),
    .LOWER_SELECT_FIRST(dat[6]),
    .LOWER_SELECT_SECOND(dat[7]),
    .CARRY_IN(dat[8]),
    .SHARED_CHAIN_IN(dat[9]),
    .REG_CHAIN_IN(dat[10]),
    .CLUSTER_CLOCK_GATE_A(ctl[0]),
    .CLUSTER_CLOCK_GATE_B(ctl[1]),
    .CLUSTER_CLOCK_GATE_C(ctl[2]),
    .CLUSTER_ASYNC_CLEAR_A(ctl[3]),
    .CLUSTER_ASYNC_CLEAR_B(ctl[4]),
    .CLUSTER_SYNC_CLEAR(ctl[5]),
    .CLUSTER_SYNC_LOAD(ctl[6]),
    .*
  );
  initial forever #10 CLK_SYS = ~CLK_SYS;
  task automatic final_report();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : final_report
  // The whole run needs under a thousand cycles, so this only catches a hung handshake.
  always @(posedge CLK_SYS) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      final_report();
    end
  end
  task automatic cmp_bit(input string what, input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask : cmp_bit
  task automatic cmp_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp_word
  task automatic axi_wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge CLK_SYS);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= d;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    forever begin
      @(posedge CLK_SYS);
      if (S_AXI_AWVALID && S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WVALID && S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
      if (S_AXI_BVALID === 1'b1) break;
    end
    S_AXI_BREADY <= 1'b0;
    cmp_word("bresp", {30'h0, er}, {30'h0, S_AXI_BRESP});
  endtask : axi_wr
  task automatic axi_rd(input logic [4:0] a, input logic [1:0] er);
    @(posedge CLK_SYS);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    forever begin
      @(posedge CLK_SYS);
      if (S_AXI_ARVALID && S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
      if (S_AXI_RVALID === 1'b1) break;
    end
    S_AXI_RREADY <= 1'b0;
    rd = S_AXI_RDATA;
    cmp_word("rresp", {30'h0, er}, {30'h0, S_AXI_RRESP});
  endtask : axi_rd
  task automatic tables(input logic [31:0] ul, input logic [31:0] uh, input logic [31:0] ll, input logic [31:0] lh);
    axi_wr(UPPER_MASK_LO_OFS, ul, RESP_OKAY);
    axi_wr(UPPER_MASK_HI_OFS, uh, RESP_OKAY);
    axi_wr(LOWER_MASK_LO_OFS, ll, RESP_OKAY);
    axi_wr(LOWER_MASK_HI_OFS, lh, RESP_OKAY);
  endtask : tables
  // Inputs change at a rising edge; outputs are looked at on the following falling edge.
  task automatic step(input logic [10:0] v, input logic [6:0] c);
    @(posedge CLK_SYS);
    fab_u.set_dat(v);
    fab_u.set_ctl(c);
    @(negedge CLK_SYS);
  endtask : step
  initial begin
    repeat (16) @(posedge CLK_SYS);
    RESET <= 1'b0;
    axi_rd(MODE_CTRL_OFS, RESP_OKAY);
    cmp_word("mode", {27'h0, MODE_RST}, rd);
    axi_rd(FLOP_CFG_OFS, RESP_OKAY);
    cmp_word("flop_cfg", {16'h0, FLOP_CFG_RST}, rd);
    axi_rd(5'h02, RESP_SLVERR);
    axi_wr(STATUS_OFS, 32'h1, RESP_SLVERR);
    for (int m = 0; m < 5; m++) begin
      axi_wr(MODE_CTRL_OFS, 32'h1 << m, RESP_OKAY);
      axi_rd(MODE_CTRL_OFS, RESP_OKAY);
      cmp_word("mode", 32'h1 << m, rd);
    end
    axi_wr(MODE_CTRL_OFS, 32'h3, RESP_OKAY);
    axi_rd(MODE_CTRL_OFS, RESP_OKAY);
    cmp_word("mode", 32'h10, rd);
    axi_wr(MODE_CTRL_OFS, {27'h0, MODE_NORMAL}, RESP_OKAY);
    // Two five-input functions sharing only c and d cannot share the cell.
    tables(32'h3cc3c33c, 32'hc33c3cc3, 32'h5aa5a55a, 32'ha55a5aa5);
    axi_rd(STATUS_OFS, RESP_OKAY);
    cmp_bit("cfg_err", 1'b1, rd[ST_CFG_ERR]);
    tables(32'h96696996, 32'h69969669, 32'h96696996, 32'h00000000);
    step(11'h001, 7'h07);
    cmp_bit("upper_comb", 1'b0, UPPER_COMB_OUTPUT);
    axi_wr(LOWER_MASK_HI_OFS, 32'h69969669, RESP_OKAY);
    axi_rd(STATUS_OFS, RESP_OKAY);
    cmp_word("status_dep", 32'h3f, {26'h0, rd[ST_UDEP_LSB +: 6]});
    cmp_bit("cfg_err", 1'b0, rd[ST_CFG_ERR]);
    for (int i = 0; i < 256; i++) begin
      step(11'(i), 7'h07);
      cmp_bit("upper_comb", ^i[5:0], UPPER_COMB_OUTPUT);
      cmp_bit("lower_comb", ^{i[7:6], i[3:0]}, LOWER_COMB_OUTPUT);
      cmp_bit("upper_local", ^i[5:0], UPPER_LOCAL_OUT);
      cmp_bit("upper_route", ^i[5:0], UPPER_ROUTE_OUT[1]);
      cmp_bit("lower_local", ^{i[7:6], i[3:0]}, LOWER_LOCAL_OUT);
      cmp_bit("lower_route", ^{i[7:6], i[3:0]}, LOWER_ROUTE_OUT[0]);
    end
    axi_wr(FLOP_CFG_OFS, 32'hffe0, RESP_OKAY);
    axi_wr(OUT_CFG_OFS, 32'h4, RESP_OKAY);
    step(11'h001, 7'h07);
    step(11'h003, 7'h07);
    cmp_bit("upper_comb", 1'b0, UPPER_COMB_OUTPUT);
    cmp_bit("upper_local", 1'b1, UPPER_LOCAL_OUT);
    step(11'h00c, 7'h47);
    step(11'h00c, 7'h67);
    cmp_bit("load_over_data", 1'b1, UPPER_LOCAL_OUT);
    step(11'h00c, 7'h07);
    cmp_bit("clear_over_load", 1'b0, UPPER_LOCAL_OUT);
    step(11'h001, 7'h07);
    step(11'h001, 7'h0f);
    cmp_bit("async_clear", 1'b0, UPPER_LOCAL_OUT);
    axi_wr(MODE_CTRL_OFS, {27'h0, MODE_EXTENDED}, RESP_OKAY);
    tables(32'h96696996, 32'h69969669, 32'h69969669, 32'h96696996);
    for (int i = 0; i < 256; i++) begin
      step(11'(i), 7'h07);
      cmp_bit("ext_comb", i[5] ? ~^{i[6], i[3:0]} : ^i[4:0], UPPER_COMB_OUTPUT);
      cmp_bit("ext_route", i[5] ? ~^{i[6], i[3:0]} : ^i[4:0], UPPER_ROUTE_OUT[0]);
      cmp_bit("ext_lower", 1'b0, LOWER_COMB_OUTPUT);
    end
    axi_wr(MODE_CTRL_OFS, {27'h0, MODE_ARITH}, RESP_OKAY);
    axi_wr(FLOP_CFG_OFS, 32'h00e0, RESP_OKAY);
    step(11'h000, 7'h07);
    step(11'h100, 7'h07);
    cmp_bit("carry_out", 1'b1, CARRY_OUT);
    cmp_bit("reg_chain", 1'b1, REG_CHAIN_OUT);
    axi_wr(MODE_CTRL_OFS, {27'h0, MODE_SHARED}, RESP_OKAY);
    step(11'h080, 7'h07);
    cmp_bit("shared_chain", 1'b1, SHARED_CHAIN_OUT);
    axi_wr(OUT_CFG_OFS, 32'h84, RESP_OKAY);
    step(11'h080, 7'h07);
    cmp_bit("feedback", 1'b0, SHARED_CHAIN_OUT);
    final_report();
  end
endmodule : tb_top
`default_nettype wire
